// ==== tb/tb_zcd_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "zcd_consts.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_zcd_top;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, config_bit_n = 1, sleep_mode = 0;
  logic want = 0, dr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 2;
  logic [31:0] haddr = 0, hwdata = 0, exp, q[$];
  logic [7:0] r = 8'h45;
  wire [31:0] hrdata;
  wire hreadyout, hresp, sink, detector_active, detector_out, irq;
  int errors = 0, compares = 0;
  always #2 hclk = ~hclk;
  zcd_src zcd_src_inst (.hclk(hclk), .hresetn(hresetn), .want(want), .sink(sink));
  zcd_top zcd_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .config_bit_n(config_bit_n),
    .sleep_mode(sleep_mode), .comparator_sink(sink), .detector_active(detector_active),
    .detector_out(detector_out), .irq(irq));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // A read notes its expected word; the monitor compares it in the data phase.
  task xfer(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1; htrans <= 2; haddr <= a; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1);
    hsel <= 0; htrans <= 0; hwdata <= d;
    if (!w) q.push_back(d);
    do @(posedge hclk); while (hreadyout !== 1);
    #1;
  endtask
  task edge_to(input logic v);
    want <= v;
    repeat (6) @(posedge hclk);
    #1;
  endtask
  task rst(input logic c);
    hresetn <= 0; config_bit_n <= c;
    repeat (8) @(posedge hclk);
    hresetn <= 1;
    repeat (3) @(posedge hclk);
    #1;
  endtask
  always @(posedge hclk)
  begin
    if (dr)
    begin
      exp = q.pop_front();
      `CHK("hrdata", exp, hrdata)
    end
    dr <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  task final_report;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    errors++;
    final_report;
  end
  initial
  begin
    rst(1);
    `CHK("active", 1'b0, detector_active)
    xfer(0, `ZCD_ADDR_CTRL, 0);
    r = lfsr(r);
    xfer(1, 32'h0000_0900, {4{r}});
    xfer(0, 32'h0000_0900, 0);
    xfer(1, `ZCD_ADDR_CTRL, 32'h0000_0080);
    `CHK("active", 1'b1, detector_active)
    xfer(1, `ZCD_ADDR_MASK, 3);
    xfer(1, `ZCD_ADDR_CTRL, 32'h0000_0083);
    edge_to(1);
    `CHK("irq", 1'b1, irq)
    xfer(0, `ZCD_ADDR_STATUS, 1);
    `CHK("irq", 1'b0, irq)
    edge_to(0);
    xfer(0, `ZCD_ADDR_STATUS, 1);
    xfer(1, `ZCD_ADDR_CTRL, 32'h0000_0082);
    edge_to(1);
    xfer(0, `ZCD_ADDR_CTRL, 32'h0000_00A2);
    xfer(0, `ZCD_ADDR_STATUS, 1);
    edge_to(0);
    xfer(0, `ZCD_ADDR_STATUS, 0);
    xfer(1, `ZCD_ADDR_CTRL, 32'h0000_0090);
    `CHK("irq", 1'b1, irq)
    xfer(1, `ZCD_ADDR_MASK, 1);
    `CHK("irq", 1'b0, irq)
    xfer(0, `ZCD_ADDR_STATUS, 2);
    xfer(0, `ZCD_ADDR_CTRL, 32'h0000_00B0);
    xfer(1, `ZCD_ADDR_MODDIS, 1);
    `CHK("active", 1'b0, detector_active)
    rst(0);
    sleep_mode <= 1;
    `CHK("active", 1'b1, detector_active)
    xfer(1, `ZCD_ADDR_MODDIS, 1);
    xfer(1, `ZCD_ADDR_CTRL, 32'h0000_0003);
    `CHK("active", 1'b1, detector_active)
    edge_to(1);
    xfer(0, `ZCD_ADDR_STATUS, 1);
    final_report;
  end
endmodule // tb_zcd_top
`default_nettype wire

// ==== tb/zcd_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module zcd_chk
(
  // Bus and detector ports
  input wire logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [31:0] haddr, hrdata,
  input wire logic [1:0]  htrans,
  input wire logic        comparator_sink, config_bit_n, detector_active, detector_out, irq
);
  logic        dr, dw;
  logic [13:0] aq;
  logic [3:0]  age;
  wire rs = dr && aq == 14'h0880;
  wire rc = dr && aq == 14'h087C;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      {dr, dw, aq, age} <= '0;
    else
    begin
      dr  <= hsel & hready & htrans[1] & !hwrite;
      dw  <= hsel & hready & htrans[1] & hwrite;
      aq  <= haddr[13:0];
      age <= age | {age[2:0], 1'b1};
    end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hreadyout && !hresp) else $error("resp not OKAY");
  a_rdata_idle: assert property (!dr |-> hrdata == 0) else $error("hrdata outside read");
  a_out_sync: assert property (!$past(dw) |-> $changed(detector_out) ==
    ($past(comparator_sink, 2) != $past(comparator_sink, 3))) else $error("out not synced");
  a_read_out: assert property (rc |-> hrdata[5] == $past(detector_out)) else $error("out bit");
  a_irq_cause: assert property ($rose(irq) |-> $past(dw) || $past(dw, 2) ||
    $past(comparator_sink, 3) != $past(comparator_sink, 4)) else $error("irq no cause");
  a_irq_sticky: assert property ($fell(irq) |-> $past(rs) || $past(dw)) else $error("drop");
  a_irq_clear: assert property (rs && !$past(dw) && !$past(dw, 2) &&
    $past(comparator_sink, 2) == $past(comparator_sink, 3) &&
    $past(comparator_sink, 3) == $past(comparator_sink, 4) |=> !irq) else $error("no clear");
  a_fuse_on: assert property (age[2] && !config_bit_n |-> detector_active) else $error("off");
  a_active_hold: assert property (age[3] && $changed(detector_active) |-> $past(dw))
    else $error("active moved");
endmodule // zcd_chk
bind zcd_top zcd_chk zcd_chk_inst (.*);
`default_nettype wire

// ==== tb/zcd_src.sv ====
`timescale 1ns/100ps
`default_nettype none
// Stands for the AC source; the comparator rests at source current while in reset.
module zcd_src
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Wanted level in, comparator level out
  input  wire logic want,
  output var  logic sink
);
  always @(posedge hclk or negedge hresetn)
    sink <= hresetn & want;
endmodule // zcd_src
`default_nettype wire

// ==== verilog/zcd_consts.vh ====
`ifndef ZCD_CONSTS_VH
`define ZCD_CONSTS_VH

// Byte addresses of the registers; ZCD_ADDR_CONTROL and ZCD_IDX_CONTROL hold the word index.
`define ZCD_ADDR_CONTROL   12'h021F
`define ZCD_IDX_CONTROL    12'h021F
`define ZCD_ADDR_CTRL      14'h087C
`define ZCD_ADDR_STATUS    14'h0880
`define ZCD_ADDR_MASK      14'h0884
`define ZCD_ADDR_MODDIS    14'h0888
`define ZCD_AW             14

// Control register fields.
`define ZCD_BIT_SEN        7
`define ZCD_BIT_OUT        5
`define ZCD_BIT_POL        4
`define ZCD_BIT_RISE       1
`define ZCD_BIT_FALL       0
`define ZCD_CTRL_RESET     8'h00

// Status and mask fields.
`define ZCD_ST_CROSS       0
`define ZCD_ST_POLCHG      1
`define ZCD_ST_W           2
`define ZCD_MASK_RESET     2'h0

// Synchroniser depth.
`define ZCD_SYNC_STAGES    2

`endif

// ==== verilog/zcd_sync.v ====
`timescale 1ns/100ps
`default_nettype none
`include "zcd_consts.vh"

module zcd_sync
(
  // Clock and reset
  input  wire hclk,
  input  wire hresetn,
  // Asynchronous level in, synchronous level out
  input  wire async_in,
  output wire sync_out
);

  reg [`ZCD_SYNC_STAGES-1:0] stage;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stage <= {`ZCD_SYNC_STAGES{1'b0}};
    else
      stage <= {stage[`ZCD_SYNC_STAGES-2:0], async_in};
  end

  assign sync_out = stage[`ZCD_SYNC_STAGES-1];

endmodule // zcd_sync

`default_nettype wire

// ==== verilog/zcd_top.v ====
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "zcd_consts.vh"

// Overview of operation
// R1 - Detector and interrupts run during Sleep.
// R2 - Config bit zero: active from reset; the code turns it on at the third clock after reset.
// R3 - Config bit zero: software enable ignored.
// R4 - Config one, enable set: detector drives pin.
// R5 - Config one, enable clear: pin released.
// R6 - Module-disable bit disables, subject to config.
// R7 - Output bit 5 high while sinking.
// R8 - Polarity bit 4 inverts output.
// R9 - Rising enable bit 1 flags rising edges.
// R10 - Falling enable bit 0 flags falling edges.
// R11 - Disabled edge direction leaves flag alone.
// R12 - Control bits reset to zero.
// R13 - Polarity change raises detector interrupt.
// R14 - Edge during clear keeps flag set.
// R15 - Comparator output double-synchronised before edges.
module zcd_top
(
  // AHB-Lite slave
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Analog detector side
  input  wire        config_bit_n,
  input  wire        sleep_mode,
  input  wire        comparator_sink,
  output wire        detector_active,
  output wire        detector_out,
  // Interrupt
  output wire        irq
);

  reg        sw_enable_bit;
  reg        polarity_select;
  reg        rise_event_enable;
  reg        fall_event_enable;
  reg        module_disable_bit;
  reg [`ZCD_ST_W-1:0] status;
  reg [`ZCD_ST_W-1:0] mask;
  reg        prev_out;
  reg        out_valid;
  reg        config_lat;
  reg        config_seen;
  reg  [1:0] cfg_wait;
  reg        active_sel;
  reg [31:0] next_rdata;
  reg        dp_write;
  reg        dp_read;
  reg [13:0] dp_addr;

  wire       sink_sync;
  wire       cfg_sync_n;
  wire       addr_phase;
  wire       rd_addr_phase;
  wire       wr_ctrl;
  wire       wr_moddis;
  wire       wr_mask;
  wire       rd_status;
  wire       rise_evt;
  wire       fall_evt;
  wire       pol_evt;
  wire [31:0] wdat;
  wire [`ZCD_ST_W-1:0] set_bits;
  wire [`ZCD_ST_W-1:0] next_status;

  // R15 comparator synchroniser
  zcd_sync u_sync
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (comparator_sink),
    .sync_out (sink_sync)
  );

  // R2 fuse level synchronised
  // The fuse is a level from outside the clock domain, so it gets the
  // same two-flop treatment as the comparator before any logic reads it.
  zcd_sync u_cfg_sync
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (config_bit_n),
    .sync_out (cfg_sync_n)
  );

  // The fuse is caught once, only after the synchroniser has filled.
  // Until then the enable falls back to the software path, which is off
  // after reset, so the pin is never driven from a half-settled level.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_wait    <= 2'h0;
      config_lat  <= 1'b0;
      config_seen <= 1'b0;
    end
    else
    begin
      if (cfg_wait != 2'h2)
        cfg_wait <= cfg_wait + 2'h1;
      if ((cfg_wait == 2'h2) && !config_seen)
      begin
        config_lat  <= ~cfg_sync_n;
        config_seen <= 1'b1;
      end
    end
  end

  // R2 active from the fuse latch, third clock after reset, when fuse clear
  // R3 enable ignored when fuse clear
  // R4 software enable drives pin
  // R5 pin released when disabled
  // R6 module disable gated by fuse
  // R1 no sleep gating applied
  // A cleared fuse wins over every software bit, so firmware can never
  // switch off a detector that the board relies on from power-up.
  always @*
  begin
    active_sel = 1'b0;
    if (config_lat)
      active_sel = 1'b1;
    else if (module_disable_bit)
      active_sel = 1'b0;
    else
      active_sel = sw_enable_bit;
  end

  assign detector_active = active_sel;

  // R7 output reads sink state
  // R8 polarity inverts output
  assign detector_out = sink_sync ^ polarity_select;

  // Zero wait states: every transfer is taken in its address phase and
  // answered in the following cycle, always with an OKAY response.
  assign addr_phase    = hsel & hready & htrans[1];
  assign rd_addr_phase = addr_phase & ~hwrite;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign wdat       = hwdata;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
      dp_addr  <= 14'h0000;
    end
    else
    begin
      dp_write <= addr_phase & hwrite;
      dp_read  <= addr_phase & ~hwrite;
      dp_addr  <= haddr[13:0];
    end
  end

  assign wr_ctrl   = dp_write & (dp_addr == `ZCD_ADDR_CTRL);
  assign wr_moddis = dp_write & (dp_addr == `ZCD_ADDR_MODDIS);
  assign wr_mask   = dp_write & (dp_addr == `ZCD_ADDR_MASK);
  assign rd_status = dp_read & (dp_addr == `ZCD_ADDR_STATUS);

  // R12 control bits reset to zero
  // The output bit is not stored here; it is read live from the pin.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sw_enable_bit     <= 1'b0;
      polarity_select   <= 1'b0;
      rise_event_enable <= 1'b0;
      fall_event_enable <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      sw_enable_bit     <= wdat[`ZCD_BIT_SEN];
      polarity_select   <= wdat[`ZCD_BIT_POL];
      rise_event_enable <= wdat[`ZCD_BIT_RISE];
      fall_event_enable <= wdat[`ZCD_BIT_FALL];
    end
  end

  // R6 module disable register
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      module_disable_bit <= 1'b0;
    else if (wr_moddis)
      module_disable_bit <= wdat[0];
  end

  // Interrupt mask, same layout as the status register.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mask <= `ZCD_MASK_RESET;
    else if (wr_mask)
      mask <= wdat[`ZCD_ST_W-1:0];
  end

  // Polarity flips move the output too; out_valid skips the first sample.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_out  <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      prev_out  <= detector_out;
      out_valid <= 1'b1;
    end
  end

  // R9 rising edge sets flag
  assign rise_evt = out_valid & rise_event_enable & detector_out & ~prev_out;
  // R10 falling edge sets flag
  assign fall_evt = out_valid & fall_event_enable & ~detector_out & prev_out;
  // R11 disabled direction ignored
  // R13 polarity change interrupts
  assign pol_evt  = wr_ctrl & (wdat[`ZCD_BIT_POL] != polarity_select);

  assign set_bits = {pol_evt, rise_evt | fall_evt};

  // R14 set wins over read clear
  // A read clears only the bits that it actually returned, so an event
  // that lands between the capture of the word and the clear survives.
  genvar gi;
  generate
    for (gi = 0; gi < `ZCD_ST_W; gi = gi + 1)
    begin : g_status
      assign next_status[gi] = (status[gi] & ~(rd_status & hrdata[gi])) | set_bits[gi];

      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          status[gi] <= 1'b0;
        else
          status[gi] <= next_status[gi];
      end
    end
  endgenerate

  assign irq = |(status & mask);

  // The read word is built in the address phase and registered, so that
  // hrdata comes straight from flip-flops at no cost in latency. A read
  // issued directly behind a write to the same register returns the value
  // from before that write; software should leave one idle cycle.
  always @*
  begin
    next_rdata = 32'h0000_0000;
    if (rd_addr_phase)
    begin
      case (haddr[13:0])
        `ZCD_ADDR_CTRL:
        begin
          next_rdata[`ZCD_BIT_SEN]  = sw_enable_bit;
          next_rdata[`ZCD_BIT_OUT]  = detector_out;
          next_rdata[`ZCD_BIT_POL]  = polarity_select;
          next_rdata[`ZCD_BIT_RISE] = rise_event_enable;
          next_rdata[`ZCD_BIT_FALL] = fall_event_enable;
        end
        `ZCD_ADDR_STATUS: next_rdata[`ZCD_ST_W-1:0] = status;
        `ZCD_ADDR_MASK:   next_rdata[`ZCD_ST_W-1:0] = mask;
        `ZCD_ADDR_MODDIS: next_rdata[0] = module_disable_bit;
        default:          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data stands for the data phase only and is zero otherwise.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else
      hrdata <= next_rdata;
  end

endmodule // zcd_top

`default_nettype wire
